// [tioc_consts.vh]
`ifndef TIOC_CONSTS_VH
`define TIOC_CONSTS_VH

// register indices on the plain register port
`define TIOC_ADDR_CH1_IO 8'h00
`define TIOC_ADDR_CH2_IO 8'h01
`define TIOC_ADDR_CH0_IRQ_EN 8'h02
`define TIOC_ADDR_IRQ_STATUS 8'h03
`define TIOC_ADDR_IRQ_MASK 8'h04
`define TIOC_ADDR_CAP_CH1A 8'h05
`define TIOC_ADDR_CAP_CH1B 8'h06
`define TIOC_ADDR_CAP_CH2A 8'h07
`define TIOC_ADDR_CAP_CH2B 8'h08

// reset values
`define TIOC_IO_RESET 8'h00
`define TIOC_IRQ_EN_RESET 8'h40
`define TIOC_IRQ_EN_RW_MASK 8'h9F
`define TIOC_IRQ_EN_RO_ONES 8'h40
`define TIOC_ZERO8 8'h00
`define TIOC_ZERO16 16'h0000

// channel 0 interrupt enable fields
`define TIOC_EN_ADC 7
`define TIOC_EN_OVF 4
`define TIOC_EN_D 3
`define TIOC_EN_C 2
`define TIOC_EN_B 1
`define TIOC_EN_A 0

// function select nibble fields
`define TIOC_FS_CAPTURE 3
`define TIOC_FS_ALT 2
`define TIOC_FS_INIT 2
`define TIOC_FS_ACT_HI 1
`define TIOC_FS_ACT_LO 0
`define TIOC_ACT_NONE 2'h0
`define TIOC_ACT_ZERO 2'h1
`define TIOC_ACT_ONE 2'h2
`define TIOC_ACT_TOGGLE 2'h3
`define TIOC_EDGE_RISE 2'h0
`define TIOC_EDGE_FALL 2'h1

// status layout: captures in low nibble, compare matches in high nibble
`define TIOC_ST_MATCH_OFS 4
`define TIOC_NREG 4

`endif

// [tioc_timer_io_control.v]
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`include "tioc_consts.vh"

module tioc_timer_io_control #(
  parameter CNT_W = 16
) (
  input wire i_clock,
  input wire i_rst_b,
  input wire [7:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output wire [15:0] o_rdata,
  input wire [CNT_W-1:0] i_timer_counter_value,
  input wire i_ch1_match_a,
  input wire i_ch1_match_b,
  input wire i_ch2_match_a,
  input wire i_ch2_match_b,
  input wire i_ch0_reg_a_event,
  input wire i_ch0_reg_c_event,
  input wire i_overflow_flag,
  input wire i_match_d_flag,
  input wire i_match_c_flag,
  input wire i_match_b_flag,
  input wire i_match_a_flag,
  input wire i_ch1_pin_a,
  input wire i_ch1_pin_b,
  input wire i_ch2_pin_a,
  input wire i_ch2_pin_b,
  output wire o_ch1_pin_a,
  output wire o_ch1_pin_b,
  output wire o_ch2_pin_a,
  output wire o_ch2_pin_b,
  output wire o_ch1_pin_a_oe,
  output wire o_ch1_pin_b_oe,
  output wire o_ch2_pin_a_oe,
  output wire o_ch2_pin_b_oe,
  output wire [CNT_W-1:0] o_ch1_general_reg_a,
  output wire [CNT_W-1:0] o_ch1_general_reg_b,
  output wire [CNT_W-1:0] o_ch2_general_reg_a,
  output wire [CNT_W-1:0] o_ch2_general_reg_b,
  output wire [3:0] o_capture_pulse,
  output wire o_adc_start_req,
  output wire o_overflow_irq,
  output wire o_match_d_irq,
  output wire o_match_c_irq,
  output wire o_match_b_irq,
  output wire o_match_a_irq,
  output wire o_irq
);

  // register index k: 0 ch1 A, 1 ch1 B, 2 ch2 A, 3 ch2 B

  function cap_hit;
    input [3:0] code;
    input rise;
    input fall;
    input ch0_evt;
    input is_ch1;
    begin
      if (!code[`TIOC_FS_CAPTURE])
        cap_hit = 1'b0;
      else if (code[`TIOC_FS_ALT] && is_ch1)
        cap_hit = ch0_evt;
      else
      begin
        // ch2 ignores the alt bit, so 11xx mirrors 10xx
        case (code[1:0])
          `TIOC_EDGE_RISE: cap_hit = rise;
          `TIOC_EDGE_FALL: cap_hit = fall;
          default: cap_hit = rise | fall;
        endcase
      end
    end
  endfunction

  function match_level;
    input [1:0] act;
    input lvl;
    begin
      case (act)
        `TIOC_ACT_ZERO: match_level = 1'b0;
        `TIOC_ACT_ONE: match_level = 1'b1;
        `TIOC_ACT_TOGGLE: match_level = ~lvl;
        default: match_level = lvl;
      endcase
    end
  endfunction

  function drives_pin;
    input [3:0] code;
    begin
      // 0000 and 0100 keep the pin off, capture codes never drive
      drives_pin = ~code[`TIOC_FS_CAPTURE] & (code[1:0] != `TIOC_ACT_NONE);
    end
  endfunction

  // reset: asynchronous assert, released through two flops
  reg rst_meta_ff;
  reg rst_n_ff;
  always @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // pin synchronisers; edge flop compares the second stage only
  wire [3:0] pin_in = {i_ch2_pin_b, i_ch2_pin_a, i_ch1_pin_b, i_ch1_pin_a};
  reg [3:0] pin_meta_ff;
  reg [3:0] pin_sync_ff;
  reg [3:0] pin_prev_ff;
  always @(posedge i_clock or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      pin_meta_ff <= 4'h0;
      pin_sync_ff <= 4'h0;
      pin_prev_ff <= 4'h0;
    end
    else
    begin
      pin_meta_ff <= pin_in;
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
    end
  end
  wire [3:0] pin_rise = pin_sync_ff & ~pin_prev_ff;
  wire [3:0] pin_fall = ~pin_sync_ff & pin_prev_ff;

  // register file
  reg [7:0] ch1_io_control_ff;
  reg [7:0] ch2_io_control_ff;
  reg [7:0] ch0_irq_enable_reg_ff;
  reg [7:0] irq_status_ff;
  reg [7:0] irq_mask_ff;
  reg [15:0] rdata_ff;

  wire wr_ch1 = i_wr && (i_addr == `TIOC_ADDR_CH1_IO);
  wire wr_ch2 = i_wr && (i_addr == `TIOC_ADDR_CH2_IO);
  wire wr_en0 = i_wr && (i_addr == `TIOC_ADDR_CH0_IRQ_EN);
  wire wr_st = i_wr && (i_addr == `TIOC_ADDR_IRQ_STATUS);
  wire wr_mask = i_wr && (i_addr == `TIOC_ADDR_IRQ_MASK);

  // low nibble is register A, high nibble register B
  wire [15:0] codes = {ch2_io_control_ff, ch1_io_control_ff};
  wire [15:0] new_codes = {i_wdata[7:0], i_wdata[7:0]};
  wire [3:0] code_wr = {wr_ch2, wr_ch2, wr_ch1, wr_ch1};
  wire [3:0] match_in = {i_ch2_match_b, i_ch2_match_a, i_ch1_match_b, i_ch1_match_a};
  wire [3:0] ch0_evt = {1'b0, 1'b0, i_ch0_reg_c_event, i_ch0_reg_a_event};

  always @(posedge i_clock or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      ch1_io_control_ff <= `TIOC_IO_RESET;
      ch2_io_control_ff <= `TIOC_IO_RESET;
      ch0_irq_enable_reg_ff <= `TIOC_IRQ_EN_RESET;
      irq_mask_ff <= `TIOC_ZERO8;
    end
    else
    begin
      if (wr_ch1)
        ch1_io_control_ff <= i_wdata[7:0];
      if (wr_ch2)
        ch2_io_control_ff <= i_wdata[7:0];
      if (wr_en0)
        ch0_irq_enable_reg_ff <= (i_wdata[7:0] & `TIOC_IRQ_EN_RW_MASK)
          | `TIOC_IRQ_EN_RO_ONES;
      if (wr_mask)
        irq_mask_ff <= i_wdata[7:0];
    end
  end

  // pin levels, captures and events per general register
  reg [3:0] pin_lvl_ff;
  reg [3:0] cap_pulse_ff;
  reg [CNT_W-1:0] cap_ff [0:`TIOC_NREG-1];
  reg [3:0] nxt_pin_lvl;
  reg [3:0] cap_hit_v;
  reg [3:0] oc_hit_v;
  reg [3:0] cur_code;
  reg [3:0] wr_code;
  reg [3:0] pin_oe_ff;
  reg [3:0] nxt_pin_oe;
  integer k;
  // own index for the clocked loop, so no variable is shared with the comb loop
  integer j;

  always @*
  begin
    nxt_pin_lvl = pin_lvl_ff;
    nxt_pin_oe = pin_oe_ff;
    cap_hit_v = 4'h0;
    oc_hit_v = 4'h0;
    cur_code = 4'h0;
    wr_code = 4'h0;
    for (k = 0; k < `TIOC_NREG; k = k + 1)
    begin
      cur_code = codes[4*k+3 -: 4];
      wr_code = new_codes[4*k+3 -: 4];
      if (code_wr[k])
        nxt_pin_oe[k] = drives_pin(wr_code);
      cap_hit_v[k] = cap_hit(cur_code, pin_rise[k], pin_fall[k], ch0_evt[k], (k < 2));
      oc_hit_v[k] = match_in[k] & ~cur_code[`TIOC_FS_CAPTURE];
      // a fresh code that drives the pin wins over a match in the same cycle
      if (code_wr[k] && drives_pin(wr_code))
        nxt_pin_lvl[k] = wr_code[`TIOC_FS_INIT];
      else if (oc_hit_v[k] && drives_pin(cur_code))
        nxt_pin_lvl[k] = match_level(cur_code[1:0], pin_lvl_ff[k]);
    end
  end

  always @(posedge i_clock or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      pin_lvl_ff <= 4'h0;
      pin_oe_ff <= 4'h0;
      cap_pulse_ff <= 4'h0;
      for (j = 0; j < `TIOC_NREG; j = j + 1)
        cap_ff[j] <= {CNT_W{1'b0}};
    end
    else
    begin
      pin_lvl_ff <= nxt_pin_lvl;
      pin_oe_ff <= nxt_pin_oe;
      cap_pulse_ff <= cap_hit_v;
      for (j = 0; j < `TIOC_NREG; j = j + 1)
        if (cap_hit_v[j])
          cap_ff[j] <= i_timer_counter_value;
    end
  end

  // sticky status: set wins over a write-one clear
  wire [7:0] st_set = {oc_hit_v, cap_hit_v};
  wire [7:0] nxt_irq_status = (irq_status_ff & ~(wr_st ? i_wdata[7:0] : `TIOC_ZERO8)) | st_set;
  wire [7:0] nxt_irq_mask = wr_mask ? i_wdata[7:0] : irq_mask_ff;
  // line built from next values so it moves in the same cycle as status and mask
  reg irq_ff;
  always @(posedge i_clock or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      irq_status_ff <= `TIOC_ZERO8;
      irq_ff <= 1'b0;
    end
    else
    begin
      irq_status_ff <= nxt_irq_status;
      irq_ff <= |(nxt_irq_status & nxt_irq_mask);
    end
  end

  // channel 0 request gating, registered to keep outputs glitch free
  reg adc_req_ff;
  reg [4:0] ch0_irq_ff;
  always @(posedge i_clock or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      adc_req_ff <= 1'b0;
      ch0_irq_ff <= 5'h00;
    end
    else
    begin
      adc_req_ff <= i_ch0_reg_a_event & ch0_irq_enable_reg_ff[`TIOC_EN_ADC];
      ch0_irq_ff[4] <= i_overflow_flag & ch0_irq_enable_reg_ff[`TIOC_EN_OVF];
      ch0_irq_ff[3] <= i_match_d_flag & ch0_irq_enable_reg_ff[`TIOC_EN_D];
      ch0_irq_ff[2] <= i_match_c_flag & ch0_irq_enable_reg_ff[`TIOC_EN_C];
      ch0_irq_ff[1] <= i_match_b_flag & ch0_irq_enable_reg_ff[`TIOC_EN_B];
      ch0_irq_ff[0] <= i_match_a_flag & ch0_irq_enable_reg_ff[`TIOC_EN_A];
    end
  end

  // read port: data stand one cycle after the strobe, unmapped reads 0
  reg [15:0] nxt_rdata;
  always @*
  begin
    nxt_rdata = `TIOC_ZERO16;
    case (i_addr)
      `TIOC_ADDR_CH1_IO: nxt_rdata = {8'h00, ch1_io_control_ff};
      `TIOC_ADDR_CH2_IO: nxt_rdata = {8'h00, ch2_io_control_ff};
      `TIOC_ADDR_CH0_IRQ_EN: nxt_rdata = {8'h00, ch0_irq_enable_reg_ff};
      `TIOC_ADDR_IRQ_STATUS: nxt_rdata = {8'h00, irq_status_ff};
      `TIOC_ADDR_IRQ_MASK: nxt_rdata = {8'h00, irq_mask_ff};
      `TIOC_ADDR_CAP_CH1A: nxt_rdata = cap_ff[0];
      `TIOC_ADDR_CAP_CH1B: nxt_rdata = cap_ff[1];
      `TIOC_ADDR_CAP_CH2A: nxt_rdata = cap_ff[2];
      `TIOC_ADDR_CAP_CH2B: nxt_rdata = cap_ff[3];
      default: nxt_rdata = `TIOC_ZERO16;
    endcase
  end

  always @(posedge i_clock or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
      rdata_ff <= `TIOC_ZERO16;
    else if (i_rd)
      rdata_ff <= nxt_rdata;
    else
      rdata_ff <= `TIOC_ZERO16;
  end

  assign o_rdata = rdata_ff;
  assign o_ch1_pin_a = pin_lvl_ff[0];
  assign o_ch1_pin_b = pin_lvl_ff[1];
  assign o_ch2_pin_a = pin_lvl_ff[2];
  assign o_ch2_pin_b = pin_lvl_ff[3];
  assign o_ch1_pin_a_oe = pin_oe_ff[0];
  assign o_ch1_pin_b_oe = pin_oe_ff[1];
  assign o_ch2_pin_a_oe = pin_oe_ff[2];
  assign o_ch2_pin_b_oe = pin_oe_ff[3];
  assign o_ch1_general_reg_a = cap_ff[0];
  assign o_ch1_general_reg_b = cap_ff[1];
  assign o_ch2_general_reg_a = cap_ff[2];
  assign o_ch2_general_reg_b = cap_ff[3];
  assign o_capture_pulse = cap_pulse_ff;
  assign o_adc_start_req = adc_req_ff;
  assign o_overflow_irq = ch0_irq_ff[4];
  assign o_match_d_irq = ch0_irq_ff[3];
  assign o_match_c_irq = ch0_irq_ff[2];
  assign o_match_b_irq = ch0_irq_ff[1];
  assign o_match_a_irq = ch0_irq_ff[0];
  assign o_irq = irq_ff;

endmodule

// [tioc_properties.sv]
`timescale 1ns/100ps
module tioc_properties #(
  parameter CNT_W = 16
) (
  input wire i_clock,
  input wire i_rst_b,
  input wire [7:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [15:0] o_rdata,
  input wire [CNT_W-1:0] i_timer_counter_value,
  input wire i_ch0_reg_a_event,
  input wire i_overflow_flag,
  input wire i_match_a_flag,
  input wire o_ch1_pin_a,
  input wire o_ch1_pin_a_oe,
  input wire o_ch2_pin_b,
  input wire o_ch2_pin_b_oe,
  input wire [CNT_W-1:0] o_ch1_general_reg_a,
  input wire [3:0] o_capture_pulse,
  input wire o_adc_start_req,
  input wire o_overflow_irq,
  input wire o_match_a_irq
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  wire wr1 = i_wr && i_addr == 8'h00;
  init_low_a: assert property (wr1 && i_wdata[1:0] != 2'h0 && i_wdata[3:2] == 2'h0
    |=> o_ch1_pin_a_oe && !o_ch1_pin_a) else $error("initial low level missing");
  init_high_a: assert property (wr1 && i_wdata[3:2] == 2'h1 && i_wdata[1:0] != 2'h0
    |=> o_ch1_pin_a_oe && o_ch1_pin_a) else $error("initial high level missing");
  pin_off_a: assert property (wr1 && !i_wdata[3] && i_wdata[1:0] == 2'h0
    |=> !o_ch1_pin_a_oe) else $error("pin driven while disabled");
  upper_nibble_a: assert property (i_wr && i_addr == 8'h01 && i_wdata[7:4] == 4'h5
    |=> o_ch2_pin_b_oe && o_ch2_pin_b) else $error("ch2 upper nibble ignored");
  fixed_bits_a: assert property (i_rd && i_addr == 8'h02 |=> o_rdata[6:5] == 2'h2)
    else $error("fixed enable bits wrong");
  adc_cause_a: assert property (o_adc_start_req |-> $past(i_ch0_reg_a_event))
    else $error("adc request without event");
  ovf_cause_a: assert property (o_overflow_irq |-> $past(i_overflow_flag))
    else $error("overflow irq without flag");
  match_cause_a: assert property (o_match_a_irq |-> $past(i_match_a_flag))
    else $error("match irq without flag");
  cap_value_a: assert property (o_capture_pulse[0]
    |-> o_ch1_general_reg_a == $past(i_timer_counter_value)) else $error("capture value wrong");
  cover property (wr1 && i_wdata[3:0] == 4'h3);
  cover property (o_capture_pulse[0]);
  cover property (o_adc_start_req);
endmodule

// [tioc_pin_model.sv]
`timescale 1ns/100ps
module tioc_pin_model (
  input wire i_clock,
  input wire [3:0] i_level,
  input wire [3:0] i_oe,
  input wire [3:0] i_dout,
  output wire [3:0] o_pin
);
  reg [3:0] ext_ff = 4'h0;
  always @(posedge i_clock)
  begin
    ext_ff <= i_level;
  end
  // outside source only wins where the block has let go of the pin
  assign o_pin = (i_oe & i_dout) | (~i_oe & ext_ff);
endmodule

// [tioc_testbench.sv]
`timescale 1ns/100ps
module testbench;
  reg i_clock = 1'h0;
  reg i_rst_b = 1'h0;
  reg [7:0] addr = 8'h00;
  reg [15:0] wdata = 16'h0000;
  reg wr = 1'h0;
  reg rd = 1'h0;
  reg [15:0] cnt = 16'h0000;
  reg [5:0] stb = 6'h00;
  reg [4:0] flag = 5'h00;
  reg [3:0] level = 4'h0;
  reg [31:0] r;
  reg [7:0] en;
  reg e;
  reg p;
  wire [15:0] rdata;
  wire [3:0] pin;
  wire [3:0] dout;
  wire [3:0] oe;
  wire [3:0] cp;
  wire [15:0] cap [0:3];
  wire adc;
  wire [4:0] irqv;
  wire irq;
  int err_total = 0;
  int cmp_count = 0;
  int seed = 51;
  int q[$];
  always #5 i_clock = ~i_clock;
  tioc_timer_io_control DUT (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_timer_counter_value(cnt),
    .i_ch1_match_a(stb[0]), .i_ch1_match_b(stb[1]), .i_ch2_match_a(stb[2]),
    .i_ch2_match_b(stb[3]), .i_ch0_reg_a_event(stb[4]), .i_ch0_reg_c_event(stb[5]),
    .i_overflow_flag(flag[4]), .i_match_d_flag(flag[3]), .i_match_c_flag(flag[2]),
    .i_match_b_flag(flag[1]), .i_match_a_flag(flag[0]), .i_ch1_pin_a(pin[0]),
    .i_ch1_pin_b(pin[1]), .i_ch2_pin_a(pin[2]), .i_ch2_pin_b(pin[3]), .o_ch1_pin_a(dout[0]),
    .o_ch1_pin_b(dout[1]), .o_ch2_pin_a(dout[2]), .o_ch2_pin_b(dout[3]),
    .o_ch1_pin_a_oe(oe[0]), .o_ch1_pin_b_oe(oe[1]), .o_ch2_pin_a_oe(oe[2]),
    .o_ch2_pin_b_oe(oe[3]), .o_ch1_general_reg_a(cap[0]), .o_ch1_general_reg_b(cap[1]),
    .o_ch2_general_reg_a(cap[2]), .o_ch2_general_reg_b(cap[3]), .o_capture_pulse(cp),
    .o_adc_start_req(adc), .o_overflow_irq(irqv[4]), .o_match_d_irq(irqv[3]),
    .o_match_c_irq(irqv[2]), .o_match_b_irq(irqv[1]), .o_match_a_irq(irqv[0]), .o_irq(irq));
  tioc_pin_model model (.i_clock(i_clock), .i_level(level), .i_oe(oe), .i_dout(dout),
    .o_pin(pin));
  function int rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task chk(input [15:0] got, input [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wreg(input [7:0] a, input [15:0] d);
    @(posedge i_clock);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge i_clock);
    wr <= 1'h0;
    #1;
  endtask
  task rreg(input [7:0] a, input [15:0] x);
    @(posedge i_clock);
    addr <= a;
    rd <= 1'h1;
    @(posedge i_clock);
    rd <= 1'h0;
    #1 chk(rdata, x);
  endtask
  task pls(input int k);
    @(posedge i_clock);
    stb[k] <= 1'h1;
    @(posedge i_clock);
    stb[k] <= 1'h0;
    #1;
  endtask
  task finish_test();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one queue is enough: captures are provoked one channel at a time
  always @(negedge i_clock)
    for (int k = 0; k < 4; k++)
      if (cp[k] === 1'h1)
        chk(cap[k], q.size() ? q.pop_front() : ~cap[k]);
  initial
  begin
    #200000;
    err_total++;
    finish_test();
  end
  initial
  begin
    repeat (3) @(posedge i_clock);
    i_rst_b <= 1'h1;
    repeat (3) @(posedge i_clock);
    rreg(8'h00, 16'h0000);
    rreg(8'h01, 16'h0000);
    rreg(8'h02, 16'h0040);
    rreg(8'h1F, 16'h0000);
    for (int i = 0; i < 8; i++)
    begin
      r = rnd();
      wreg(8'h02, {8'h00, r[7:0]});
      en = (r[7:0] & 8'h9F) | 8'h40;
      rreg(8'h02, {8'h00, en});
      @(posedge i_clock);
      flag <= r[12:8];
      stb[4] <= r[13];
      @(posedge i_clock);
      stb[4] <= 1'h0;
      #1 chk(irqv, r[12:8] & en[4:0]);
      chk(adc, r[13] & en[7]);
    end
    for (int k = 0; k < 4; k++)
      for (int c = 0; c < 8; c++)
      begin
        wreg(8'(k >> 1), 16'(c << (k[0] * 4)));
        e = (c & 3) != 0;
        p = c[2];
        chk(oe[k], e);
        chk(dout[k] & e, p & e);
        repeat (2)
        begin
          pls(k);
          p = (c & 3) == 3 ? !p : (c & 3) == 2;
          chk(dout[k] & e, p & e);
        end
      end
    rreg(8'h03, 16'h00F0);
    wreg(8'h03, 16'h00FF);
    for (int k = 0; k < 4; k++)
      for (int c = 8; c < 16; c++)
        if (k > 1 || c < 12)
        begin
          wreg(8'(k >> 1), 16'(c << (k[0] * 4)));
          for (int v = 1; v >= 0; v--)
          begin
            r = rnd();
            @(posedge i_clock);
            cnt <= r[15:0];
            level[k] <= v[0];
            if (c[1] || c[0] != v[0])
              q.push_back(r[15:0]);
            repeat (6) @(posedge i_clock);
            #1 chk(16'(q.size()), 16'h0000);
          end
        end
    rreg(8'h03, 16'h000F);
    wreg(8'h04, 16'h0000);
    chk(irq, 1'h0);
    wreg(8'h04, 16'h0004);
    chk(irq, 1'h1);
    wreg(8'h03, 16'h0004);
    chk(irq, 1'h0);
    wreg(8'h00, 16'h00CC);
    for (int k = 4; k < 6; k++)
    begin
      r = rnd();
      @(posedge i_clock);
      cnt <= r[15:0];
      q.push_back(r[15:0]);
      pls(k);
      @(posedge i_clock);
      #1 chk(16'(q.size()), 16'h0000);
      rreg(8'(k + 1), r[15:0]);
    end
    finish_test();
  end
endmodule
bind tioc_timer_io_control tioc_properties #(.CNT_W(CNT_W)) chk_i (.*);
